// ---- verilog/sdl_pkg.sv ----
`default_nettype none
package sdl_pkg;
  // Word shape on the serial link
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;

  // Codes (straight binary unipolar, offset binary bipolar)
  localparam logic [WORD_W-1:0] CODE_MIN = 16'h0000;
  localparam logic [WORD_W-1:0] CODE_MID = 16'h8000;
  localparam logic [WORD_W-1:0] CODE_FULL = 16'hffff;

  // Value after the system reset, before any pin reset is seen
  localparam logic [WORD_W-1:0] CODE_SYS_RESET = CODE_MIN;

  // Synchroniser slots for pin inputs
  localparam int unsigned PIN_N = 4;
  localparam int unsigned PIN_CS = 0;
  localparam int unsigned PIN_LOAD = 1;
  localparam int unsigned PIN_RSTN = 2;
  localparam int unsigned PIN_SEL = 3;

  // Bits shifted since the last clear sit in the low end, the preset fills the rest
  function automatic logic [WORD_W-1:0] sdl_merge(input logic [WORD_W-1:0] shifted,
                                                 input logic [CNT_W-1:0] count,
                                                 input logic [WORD_W-1:0] preset);
    logic [WORD_W-1:0] mask;
    mask = (16'h0001 << count) - 16'h0001;
    return ((preset << count) & ~mask) | (shifted & mask);
  endfunction : sdl_merge

  function automatic logic [WORD_W-1:0] sdl_reset_code(input logic select_mid);
    return select_mid ? CODE_MID : CODE_MIN;
  endfunction : sdl_reset_code
endpackage : sdl_pkg
`default_nettype wire

// ---- verilog/sdl_shift.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdl_shift
  import sdl_pkg::*;
(
  // Link side
  input wire logic shift_clk,
  input wire logic clear,
  input wire logic serial_in,
  // Preset word, only changes while clear is held
  input wire logic [WORD_W-1:0] preset_word,
  // State
  output logic [WORD_W-1:0] shift_word,
  output logic serial_out
);
  logic [WORD_W-1:0] sr;
  logic [CNT_W-1:0] count;
  logic clear_hi;
  logic clear_lo;

  // One bit in per edge, MSB first, sixteen stages deep
  always_ff @(posedge shift_clk or posedge clear) begin
    if (clear) begin
      sr <= '0;
    end else begin
      sr <= {sr[WORD_W-2:0], serial_in};
    end
  end

  // Counts shifts since clear so the preset can be shown until pushed out
  always_ff @(posedge shift_clk or posedge clear) begin
    if (clear) begin
      count <= '0;
    end else if (count != CNT_FULL) begin
      count <= count + 5'h01;
    end
  end

  // The shift register is the input register
  assign shift_word = sdl_merge(sr, count, preset_word);

  // Old word leaves MSB first while new bits enter. Under reset the output already
  // shows the preset MSB, so a mid-scale word also leaves whole.
  assign clear_hi = clear & preset_word[WORD_W-1];
  assign clear_lo = clear & ~preset_word[WORD_W-1];

  always_ff @(posedge shift_clk or posedge clear_hi or posedge clear_lo) begin
    if (clear_hi) begin
      serial_out <= 1'b1;
    end else if (clear_lo) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= shift_word[WORD_W-2];
    end
  end
endmodule : sdl_shift
`default_nettype wire

// ---- verilog/sdl_top.sv ----
// Operation
// - Chip select high: shift register ignores serial clock and data.
// - Chip select low: serial output driven and shifting enabled.
// - One bit captured per rising serial clock, 16-bit words, MSB first.
// - Code is straight or offset binary: 0000 low, 8000 mid, ffff top.
// - Load strobe rising edge copies input register into the converter register.
// - Load strobe edge accepted at any time, unrelated to serial clock.
// - Repeated loads of an unchanged input register leave output unchanged.
// - Chip select rising while serial clock low causes one extra shift.
// - Byte mode: chip select high freezes shifting and keeps partial contents.
// - Continuous mode: one bit in and one out per serial clock.
// - Load transfers bits from the sixteen preceding rising serial clock edges.
// - Held word is sent out MSB first while new bits enter.
// - Low reset pin overrides serial interface and load strobe.
// - Reset with select high forces both registers to 8000.
// - Reset with select low forces both registers to 0000.
// - Select change during reset switches the forced value at once.
// - Serial output repeats input delayed by sixteen serial clocks.
`timescale 1ns/100ps
`default_nettype none
module sdl_top
  import sdl_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Control pins
  input wire logic dac_load_strobe,
  input wire logic dac_reset_n,
  input wire logic reset_value_select,
  // Converter side
  output logic [WORD_W-1:0] dac_code,
  output logic load_done,
  output logic reset_active
);
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;
  logic load_prev;
  logic load_edge;
  logic reset_hold;
  logic [WORD_W-1:0] preset_word;
  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] load_snapshot;
  logic shift_clk;
  logic link_serial_out;

  // Two-flop synchronisers for every pin read by clk logic
  always_ff @(posedge clk) begin
    pin_meta <= {reset_value_select, dac_reset_n, dac_load_strobe, cs_n};
    pin_sync <= pin_meta;
  end

  // Pin reset level, also held under the system reset
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_hold <= 1'b1;
    end else begin
      reset_hold <= ~pin_sync[PIN_RSTN];
    end
  end

  // Forced value follows the select while reset is low
  always_ff @(posedge clk) begin
    if (rst) begin
      preset_word <= CODE_SYS_RESET;
    end else if (!pin_sync[PIN_RSTN]) begin
      preset_word <= sdl_reset_code(pin_sync[PIN_SEL]);
    end
  end

  // Shift clock only rises with chip select low, or when chip select rises
  // over a low serial clock; that second edge is the documented extra shift.
  // Chip select high holds it high, so shifting freezes.
  assign shift_clk = sclk | cs_n;

  sdl_shift u_shift (
    .shift_clk(shift_clk),
    .clear(reset_hold),
    .serial_in(serial_in),
    .preset_word(preset_word),
    .shift_word(shift_word),
    .serial_out(link_serial_out)
  );

  assign serial_out = link_serial_out;

  // Output enable follows chip select, lagging it by the synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= ~pin_sync[PIN_CS];
    end
  end

  // The load edge itself freezes the last sixteen bits, so the serial clock may
  // run on right after it; the clk side reads the snapshot once the edge is
  // synchronised and it no longer moves.
  always_ff @(posedge dac_load_strobe) begin
    load_snapshot <= shift_word;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      load_prev <= 1'b0;
    end else begin
      load_prev <= pin_sync[PIN_LOAD];
    end
  end

  assign load_edge = pin_sync[PIN_LOAD] & ~load_prev;

  // Converter register: reset overrides any load
  always_ff @(posedge clk) begin
    if (rst) begin
      dac_code <= CODE_SYS_RESET;
    end else if (!pin_sync[PIN_RSTN]) begin
      dac_code <= sdl_reset_code(pin_sync[PIN_SEL]);
    end else if (load_edge) begin
      dac_code <= load_snapshot;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      load_done <= 1'b0;
    end else begin
      load_done <= load_edge & pin_sync[PIN_RSTN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_active <= 1'b1;
    end else begin
      reset_active <= ~pin_sync[PIN_RSTN];
    end
  end
endmodule : sdl_top
`default_nettype wire

// ---- tb/sdl_top_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdl_top_checker
  import sdl_pkg::*;
(
  // Watched ports
  input wire logic clk, rst, cs_n, dac_load_strobe, dac_reset_n, reset_value_select,
  input wire logic serial_out_oe, load_done, reset_active,
  input wire logic [WORD_W-1:0] dac_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_load;
    $rose(dac_load_strobe) && dac_reset_n;
  endsequence
  sequence s_hold_mid;
    (!dac_reset_n && reset_value_select) [*6];
  endsequence
  AST_OE_ON: assert property ($fell(cs_n) |-> ##[2:4] serial_out_oe)
    else $error("oe late");
  AST_OE_OFF: assert property ($rose(cs_n) |-> ##[2:4] !serial_out_oe)
    else $error("oe stuck");
  AST_LOAD_SRC: assert property (s_load |-> ##[2:5] load_done)
    else $error("load lost");
  AST_LOAD_PULSE: assert property (load_done |=> !load_done)
    else $error("load pulse long");
  AST_RST_MID: assert property (s_hold_mid |-> dac_code == CODE_MID)
    else $error("mid code wrong");
  AST_RST_MIN: assert property ((!dac_reset_n && !reset_value_select) [*6] |->
    dac_code == CODE_MIN) else $error("min code wrong");
  AST_RST_NOLOAD: assert property (reset_active |-> !load_done)
    else $error("load in reset");
  AST_CODE_HOLD: assert property (!$stable(dac_code) |->
    load_done || reset_active || $past(reset_active)) else $error("code moved");
endmodule : sdl_top_checker
bind sdl_top sdl_top_checker chk (.*);
`default_nettype wire

// ---- tb/sdl_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdl_host (
  // Link
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out
);
  logic [31:0] got = '0;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic open_frame;
    cs_n = 1'b0;
    #80;
  endtask : open_frame
  // Old word is read just before each shifting edge
  task automatic put_bit(input logic b);
    sclk = 1'b0;
    #5;
    serial_in = b;
    #10;
    got = {got[30:0], serial_out};
    sclk = 1'b1;
    #15;
  endtask : put_bit
  // Data line is inverted before chip select rises; a bad close costs one shift
  task automatic close_frame(input logic bad);
    #5;
    serial_in = ~serial_in;
    if (bad) begin
      sclk = 1'b0;
      #15;
    end
    cs_n = 1'b1;
    #15;
    sclk = 1'b1;
    #50;
  endtask : close_frame
endmodule : sdl_host
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sdl_pkg::*;
  logic clk, rst, dac_load_strobe, dac_reset_n, reset_value_select, sclk, cs_n;
  logic serial_in, serial_out, serial_out_oe, load_done, reset_active;
  logic [WORD_W-1:0] dac_code;
  int error_cnt = 0;
  int n_tests = 0;
  sdl_host host (.*);
  sdl_top uut (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic load;
    tick(1);
    dac_load_strobe = 1'b1;
    tick(3);
    check("done", load_done, dac_reset_n);
    dac_load_strobe = 1'b0;
    tick(6);
  endtask : load
  task automatic frame(input logic [31:0] w, input int n, input logic split, input logic bad);
    host.open_frame();
    check("oe on", serial_out_oe, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      host.put_bit(w[i]);
      if (split && i == 8) begin
        host.close_frame(1'b0);
        check("oe gap", serial_out_oe, 1'b0);
        host.open_frame();
      end
    end
    host.close_frame(bad);
    check("oe off", serial_out_oe, 1'b0);
  endtask : frame
  task automatic t_reset;
    dac_reset_n = 1'b0;
    tick(8);
    check("mid", dac_code, CODE_MID);
    check("ract", reset_active, 1'b1);
    load();
    check("held", dac_code, CODE_MID);
    reset_value_select = 1'b0;
    tick(6);
    check("min", dac_code, CODE_MIN);
    dac_reset_n = 1'b1;
  endtask : t_reset
  task automatic t_word;
    frame(32'h3ca5, 16, 1'b0, 1'b0);
    check("ract off", reset_active, 1'b0);
    check("out", host.got[15:0], CODE_MIN);
    load();
    check("code", dac_code, 16'h3ca5);
    load();
    check("again", dac_code, 16'h3ca5);
  endtask : t_word
  task automatic t_bytes;
    frame(32'h5a0f, 16, 1'b1, 1'b0);
    check("bout", host.got[15:0], 16'h3ca5);
    load();
    check("bcode", dac_code, 16'h5a0f);
  endtask : t_bytes
  task automatic t_stream;
    frame(32'h1234fedc, 32, 1'b0, 1'b0);
    check("sout", host.got, 32'h5a0f1234);
    load();
    check("scode", dac_code, 16'hfedc);
    frame(32'h8001, 16, 1'b0, 1'b1);
    load();
    check("extra", dac_code, 16'h0002);
  endtask : t_stream
  task automatic t_mid_out;
    reset_value_select = 1'b1;
    dac_reset_n = 1'b0;
    tick(8);
    dac_reset_n = 1'b1;
    tick(4);
    frame(32'hffff, 16, 1'b0, 1'b0);
    check("mout", host.got[15:0], CODE_MID);
    load();
    check("full", dac_code, CODE_FULL);
  endtask : t_mid_out
  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    rst = 1'b1;
    dac_load_strobe = 1'b0;
    dac_reset_n = 1'b1;
    reset_value_select = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    t_reset();
    t_word();
    t_bytes();
    t_stream();
    t_mid_out();
    give_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
